// ==== common/tsd_defines.svh ====
// Opcode encodings, field positions, flag mask layout and clock counts for the test/scan decoder
`ifndef TSD_DEFINES_SVH
`define TSD_DEFINES_SVH

// Opcode bytes
`define TSD_OPC_ESC         8'h0F
`define TSD_OPC_GRP_IMM     8'hBA
`define TSD_OPC_BT_REG      8'hA3
`define TSD_OPC_BTC_REG     8'hBB
`define TSD_OPC_BTR_REG     8'hB3
`define TSD_OPC_FWD_SCAN    8'hBC
`define TSD_OPC_REV_SCAN    8'hBD
`define TSD_OPC_BOUND       8'h62
`define TSD_OPC_PRIV_ADJ    8'h63
`define TSD_OPC_AND_RM_HI   6'h08
`define TSD_OPC_AND_ACC_HI  7'h12
`define TSD_OPC_GRP8_HI     6'h20

// ModR/M reg field selectors
`define TSD_REG_AND         3'h4
`define TSD_REG_TEST        3'h4
`define TSD_REG_SET         3'h5
`define TSD_REG_CLEAR       3'h6
`define TSD_REG_COMPLEMENT  3'h7
`define TSD_MOD_REGISTER    2'h3

// Flag mask bit positions
`define TSD_FLAG_OF         8
`define TSD_FLAG_DF         7
`define TSD_FLAG_IF         6
`define TSD_FLAG_TF         5
`define TSD_FLAG_SF         4
`define TSD_FLAG_ZF         3
`define TSD_FLAG_AF         2
`define TSD_FLAG_PF         1
`define TSD_FLAG_CF         0
`define TSD_MASK_NONE       9'h000
`define TSD_MASK_CARRY      9'h001
`define TSD_MASK_ZERO       9'h008
`define TSD_MASK_AND        9'h11F

// Clock counts (register operand / memory operand)
`define TSD_LAT_AND         8'h01
`define TSD_LAT_BT_IMM      8'h01
`define TSD_LAT_BT_REG      8'h01
`define TSD_LAT_BT_MEM      8'h07
`define TSD_LAT_BTX_IMM     8'h02
`define TSD_LAT_BTX_REG     8'h02
`define TSD_LAT_BTX_MEM     8'h08
`define TSD_LAT_SCAN_REG    8'h04
`define TSD_LAT_FWD_MEM     8'h09
`define TSD_LAT_REV_MEM     8'h0B
`define TSD_LAT_BOUND_IN    8'h07
`define TSD_LAT_BOUND_OUT   8'h08
`define TSD_LAT_PRIV_ADJ    8'h09
`define TSD_VEC_BOUND       8'h05

// Reset values
`define TSD_RST_LAT         8'h00
`define TSD_RST_VEC         8'h00

`endif

// ==== common/tsd_pkg.sv ====
// Types shared by the test/scan decoder modules
package tsd_pkg;

   typedef enum logic [3:0] {
      OP_NONE                   = 4'b0000,
      OP_AND                    = 4'b0001,
      OP_BIT_TEST               = 4'b0010,
      OP_BIT_TEST_COMPLEMENT    = 4'b0011,
      OP_BIT_TEST_CLEAR         = 4'b0100,
      OP_BIT_TEST_SET           = 4'b0101,
      OP_FORWARD_BIT_SCAN       = 4'b0110,
      OP_REVERSE_BIT_SCAN       = 4'b0111,
      OP_BOUND_CHECK            = 4'b1000,
      OP_PRIVILEGE_ADJUST       = 4'b1001,
      OP_INVALID                = 4'b1010
   } tsd_op_t;

   typedef struct packed {
      logic [7:0] opc0;
      logic [7:0] opc1;
      logic [7:0] modrm;
   } tsd_instr_t;

   typedef struct packed {
      tsd_op_t    op;
      logic [8:0] flag_mask;
      logic [7:0] latency;
      logic       trap;
      logic [7:0] vector;
   } tsd_dec_t;

   typedef struct packed {
      logic [7:0] lat_reg;
      logic [7:0] lat_mem;
      logic       add_n;
      logic [8:0] flag_mask;
   } tsd_info_t;

endpackage

// ==== design/tsd_lat_calc.sv ====
// Latency selector: register or memory count, plus the scanned bit count where it applies
`timescale 1ns/1ps
`include "tsd_defines.svh"

module tsd_lat_calc
   import tsd_pkg::*;
(
   // Selection inputs
   input  wire tsd_info_t  info,
   input  wire logic       is_mem,
   input  wire logic [5:0] scan_count,
   // Result
   output logic      [7:0] latency
);

   // Scan count only extends the memory-operand figure, so register cases stay fixed
   wire logic [7:0] scan_add = info.add_n ? {2'b00, scan_count} : 8'h00;
   wire logic [7:0] mem_lat  = 8'(info.lat_mem + scan_add);

   assign latency = is_mem ? mem_lat : info.lat_reg;

endmodule // tsd_lat_calc

// ==== design/tsd_decoder.sv ====
// Decoder for AND, bound check, privilege adjust, bit scan and bit test instructions
`timescale 1ns/1ps
`include "tsd_defines.svh"

module tsd_decoder
   import tsd_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       arst_n,
   // Instruction from fetch
   input  wire logic       in_valid,
   input  wire tsd_instr_t in_instr,
   input  wire logic       mode_prot,
   input  wire logic       bound_out_of_range,
   input  wire logic [5:0] scan_count,
   // Decoded operation to pipeline
   output logic            dec_valid,
   output tsd_dec_t        dec_out
);

   // Field helpers used by several decode terms
   function automatic logic [2:0] modrm_reg(input logic [7:0] modrm);
      return modrm[5:3];
   endfunction

   function automatic logic operand_is_mem(input logic [7:0] modrm);
      return modrm[7:6] != `TSD_MOD_REGISTER;
   endfunction

   // Per-operation table of counts and flag masks
   function automatic tsd_info_t op_info(input tsd_op_t op, input logic oor, input logic imm);
      tsd_info_t i;
      i = '{lat_reg: `TSD_RST_LAT, lat_mem: `TSD_RST_LAT, add_n: 1'b0, flag_mask: `TSD_MASK_NONE};
      unique case (op)
         OP_AND: begin
            i = '{`TSD_LAT_AND, `TSD_LAT_AND, 1'b0, `TSD_MASK_AND};
         end
         OP_BIT_TEST: begin
            if (imm) begin
               i = '{`TSD_LAT_BT_IMM, `TSD_LAT_BT_IMM, 1'b0, `TSD_MASK_CARRY};
            end else begin
               i = '{`TSD_LAT_BT_REG, `TSD_LAT_BT_MEM, 1'b0, `TSD_MASK_CARRY};
            end
         end
         OP_BIT_TEST_COMPLEMENT, OP_BIT_TEST_CLEAR, OP_BIT_TEST_SET: begin
            if (imm) begin
               i = '{`TSD_LAT_BTX_IMM, `TSD_LAT_BTX_IMM, 1'b0, `TSD_MASK_CARRY};
            end else begin
               i = '{`TSD_LAT_BTX_REG, `TSD_LAT_BTX_MEM, 1'b0, `TSD_MASK_CARRY};
            end
         end
         OP_FORWARD_BIT_SCAN: begin
            i = '{`TSD_LAT_SCAN_REG, `TSD_LAT_FWD_MEM, 1'b1, `TSD_MASK_ZERO};
         end
         OP_REVERSE_BIT_SCAN: begin
            i = '{`TSD_LAT_SCAN_REG, `TSD_LAT_REV_MEM, 1'b1, `TSD_MASK_ZERO};
         end
         OP_BOUND_CHECK: begin
            i.lat_reg = oor ? `TSD_LAT_BOUND_OUT : `TSD_LAT_BOUND_IN;
            i.lat_mem = i.lat_reg;
         end
         OP_PRIVILEGE_ADJUST: begin
            i = '{`TSD_LAT_PRIV_ADJ, `TSD_LAT_PRIV_ADJ, 1'b0, `TSD_MASK_ZERO};
         end
         OP_NONE, OP_INVALID: begin
            i = '{`TSD_RST_LAT, `TSD_RST_LAT, 1'b0, `TSD_MASK_NONE};
         end
         default: begin
            i = '{`TSD_RST_LAT, `TSD_RST_LAT, 1'b0, `TSD_MASK_NONE};
         end
      endcase
      return i;
   endfunction

   // Opcode field extraction
   wire logic [2:0] sub_op  = modrm_reg(in_instr.modrm);
   wire logic       is_mem  = operand_is_mem(in_instr.modrm);
   wire logic       esc     = in_instr.opc0 == `TSD_OPC_ESC;
   wire logic       esc_grp = esc && (in_instr.opc1 == `TSD_OPC_GRP_IMM);

   // AND forms: 20-23 register/memory, 24-25 accumulator, 80-83 with reg field 100
   wire logic hit_and = (in_instr.opc0[7:2] == `TSD_OPC_AND_RM_HI)
                     || (in_instr.opc0[7:1] == `TSD_OPC_AND_ACC_HI)
                     || ((in_instr.opc0[7:2] == `TSD_OPC_GRP8_HI) && (sub_op == `TSD_REG_AND));

   // Bit test family, immediate and register-indexed
   wire logic hit_bt_imm  = esc_grp && (sub_op == `TSD_REG_TEST);
   wire logic hit_btc_imm = esc_grp && (sub_op == `TSD_REG_COMPLEMENT);
   wire logic hit_btr_imm = esc_grp && (sub_op == `TSD_REG_CLEAR);
   wire logic hit_bts_imm = esc_grp && (sub_op == `TSD_REG_SET);
   wire logic hit_bt_reg  = esc && (in_instr.opc1 == `TSD_OPC_BT_REG);
   wire logic hit_btc_reg = esc && (in_instr.opc1 == `TSD_OPC_BTC_REG);
   wire logic hit_btr_reg = esc && (in_instr.opc1 == `TSD_OPC_BTR_REG);
   wire logic hit_imm     = hit_bt_imm || hit_btc_imm || hit_btr_imm || hit_bts_imm;

   // Scans, bound check and privilege adjust
   wire logic hit_fwd   = esc && (in_instr.opc1 == `TSD_OPC_FWD_SCAN);
   wire logic hit_rev   = esc && (in_instr.opc1 == `TSD_OPC_REV_SCAN);
   wire logic hit_bound = in_instr.opc0 == `TSD_OPC_BOUND;
   wire logic hit_priv  = in_instr.opc0 == `TSD_OPC_PRIV_ADJ;

   // Operation select; privilege adjust outside protected mode is flagged invalid
   wire tsd_op_t op_sel =
        hit_and                     ? OP_AND :
        (hit_bt_imm || hit_bt_reg)  ? OP_BIT_TEST :
        (hit_btc_imm || hit_btc_reg)? OP_BIT_TEST_COMPLEMENT :
        (hit_btr_imm || hit_btr_reg)? OP_BIT_TEST_CLEAR :
        hit_bts_imm                 ? OP_BIT_TEST_SET :
        hit_fwd                     ? OP_FORWARD_BIT_SCAN :
        hit_rev                     ? OP_REVERSE_BIT_SCAN :
        hit_bound                   ? OP_BOUND_CHECK :
        hit_priv                    ? (mode_prot ? OP_PRIVILEGE_ADJUST : OP_INVALID) :
                                      OP_NONE;

   wire tsd_info_t  info_sel  = op_info(op_sel, bound_out_of_range, hit_imm);
   wire logic       trap_sel  = (op_sel == OP_BOUND_CHECK) && bound_out_of_range;
   wire logic [7:0] vec_sel   = trap_sel ? `TSD_VEC_BOUND : `TSD_RST_VEC;
   // Immediate forms never use the memory figure of the register-indexed variant
   wire logic       mem_sel   = is_mem && !hit_imm;
   wire logic [7:0] lat_sel;

   // Register or memory count selection
   tsd_lat_calc u_lat (
      .info       (info_sel),
      .is_mem     (mem_sel),
      .scan_count (scan_count),
      .latency    (lat_sel)
   );

   // Next state: the whole decode word moves as one, so nothing arrives out of step
   tsd_dec_t dec_next;
   assign dec_next = '{op: op_sel, flag_mask: info_sel.flag_mask, latency: lat_sel,
                       trap: trap_sel, vector: vec_sel};

   tsd_dec_t dec_reg;
   logic     dec_valid_reg;

   // Decode register: one cycle from taken instruction to result
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         dec_valid_reg <= 1'b0;
         dec_reg       <= '{op: OP_NONE, flag_mask: `TSD_MASK_NONE, latency: `TSD_RST_LAT,
                            trap: 1'b0, vector: `TSD_RST_VEC};
      end else begin
         dec_valid_reg <= in_valid;
         if (in_valid) begin
            dec_reg <= dec_next;
         end
      end
   end

   assign dec_valid = dec_valid_reg;
   assign dec_out   = dec_reg;

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   a_bt_imm_decode: assert property (in_valid && hit_bt_imm |=> dec_valid && dec_out.op == OP_BIT_TEST
      && dec_out.latency == 8'h01 && dec_out.flag_mask == 9'h001)
      else $error("bit test immediate decoded wrongly");

   a_btc_latency: assert property (in_valid && hit_btc_reg |=> dec_out.op == OP_BIT_TEST_COMPLEMENT
      && dec_out.latency == ($past(is_mem) ? 8'h08 : 8'h02))
      else $error("complement latency wrong");

   a_btr_decode: assert property (in_valid && (hit_btr_imm || hit_btr_reg) |=>
      dec_out.op == OP_BIT_TEST_CLEAR && dec_out.flag_mask == 9'h001)
      else $error("clear decode wrong");

   a_bts_flags: assert property (in_valid && hit_bts_imm |=> dec_out.op == OP_BIT_TEST_SET
      && dec_out.flag_mask == 9'h001 && dec_out.latency == 8'h02)
      else $error("set decode wrong");

   a_fwd_scan_lat: assert property (in_valid && hit_fwd |=> dec_out.flag_mask == 9'h008
      && dec_out.latency == ($past(is_mem) ? 8'(8'h09 + $past(scan_count)) : 8'h04))
      else $error("forward scan latency wrong");

   a_rev_scan_lat: assert property (in_valid && hit_rev |=>
      dec_out.latency == ($past(is_mem) ? 8'(8'h0B + $past(scan_count)) : 8'h04))
      else $error("reverse scan latency wrong");

   a_and_one_clock: assert property (in_valid && hit_and |=> dec_out.op == OP_AND
      && dec_out.latency == 8'h01)
      else $error("and decode wrong");

   a_bound_trap: assert property (in_valid && hit_bound |=>
      (dec_out.trap == $past(bound_out_of_range))
      && (dec_out.trap ? (dec_out.vector == 8'h05 && dec_out.latency == 8'h08) : dec_out.latency == 8'h07))
      else $error("bound check trap or latency wrong");

   a_priv_mode: assert property (in_valid && hit_priv |=>
      ($past(mode_prot) ? (dec_out.op == OP_PRIVILEGE_ADJUST && dec_out.latency == 8'h09
                           && dec_out.flag_mask == 9'h008) : dec_out.op == OP_INVALID))
      else $error("privilege adjust mode check wrong");

   a_bt_reg_slash: assert property (in_valid && hit_bt_reg && is_mem |=> dec_out.latency == 8'h07)
      else $error("memory operand latency not selected");

   a_valid_follows: assert property (dec_valid == $past(in_valid))
      else $error("decode valid not one cycle after input");

   // Idle cycle: no pulse, and the last result stays put for the pipeline
   a_idle_hold: assert property (!in_valid |=> !dec_valid && $stable(dec_out))
      else $error("decode output moved without an instruction");

   c_bound_trap:   cover property (in_valid && hit_bound && bound_out_of_range ##1 dec_out.trap);
   c_scan_mem:     cover property (in_valid && hit_rev && is_mem && scan_count == 6'h3F);
   c_priv_invalid: cover property (in_valid && hit_priv && !mode_prot);
   c_back_to_back: cover property (in_valid && hit_btc_reg ##1 in_valid && hit_fwd);

endmodule // tsd_decoder

// ==== verification/tsd_pipe_model.sv ====
// Pipeline-side partner model: takes every decoded operation the decoder offers
`timescale 1ns/1ps
module tsd_pipe_model
   import tsd_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   // Decoded operation from the decoder
   input  wire logic        dec_valid,
   input  wire tsd_dec_t    dec_out,
   // Observation
   output logic      [15:0] taken_count,
   output tsd_dec_t         last_dec
);
   // No back-pressure exists, so each pulse is exactly one accepted operation
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         taken_count <= 16'h0000;
         last_dec    <= '0;
      end else if (dec_valid) begin
         taken_count <= taken_count + 16'h0001;
         last_dec    <= dec_out;
      end
   end
endmodule // tsd_pipe_model

// ==== verification/tb_tsd_decoder.sv ====
// Scenario testbench for the test/scan decoder
`timescale 1ns/1ps
module tb_tsd_decoder;
   import tsd_pkg::*;
   logic        clk_sys = 1'b0;
   logic        arst_n = 1'b0;
   logic        in_valid = 1'b0;
   tsd_instr_t  in_instr = '0;
   logic        mode_prot = 1'b0;
   logic        bound_out_of_range = 1'b0;
   logic  [5:0] scan_count = 6'h00;
   logic        dec_valid;
   tsd_dec_t    dec_out;
   logic [15:0] taken_count;
   tsd_dec_t    last_dec;
   int          num_errors = 0;
   int          n_compared = 0;
   int          n_sent = 0;

   // Core clock, 8 ns period
   always #4 clk_sys = ~clk_sys;

   tsd_decoder DUT (.clk_sys(clk_sys), .arst_n(arst_n), .in_valid(in_valid), .in_instr(in_instr),
      .mode_prot(mode_prot), .bound_out_of_range(bound_out_of_range), .scan_count(scan_count),
      .dec_valid(dec_valid), .dec_out(dec_out));

   tsd_pipe_model PIPE (.clk_sys(clk_sys), .arst_n(arst_n), .dec_valid(dec_valid), .dec_out(dec_out),
      .taken_count(taken_count), .last_dec(last_dec));

   task automatic check(input logic [29:0] seen, input logic [29:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Present one instruction for one edge; the answer is due one cycle later
   task automatic send(input logic [7:0] o0, o1, m, input logic p, b, input logic [5:0] n);
      // One idle edge first, so in_valid is never lowered and raised in one time step
      @(negedge clk_sys);
      in_valid = 1'b1;
      in_instr = {o0, o1, m};
      mode_prot = p;
      bound_out_of_range = b;
      scan_count = n;
      @(posedge clk_sys);
      @(negedge clk_sys);
      in_valid = 1'b0;
      n_sent++;
      check({29'h0, dec_valid}, 30'h1);
   endtask

   // Whole result compared, vector included
   task automatic go(input logic [7:0] o0, o1, m, input logic p, b, input logic [5:0] n,
                     input tsd_op_t op, input logic [8:0] mk, input logic [7:0] lat, input logic tr,
                     input logic [7:0] vec);
      send(o0, o1, m, p, b, n);
      check(dec_out, {op, mk, lat, tr, vec});
   endtask

   // Vector left out where no trap is raised and its value is open
   task automatic go_head(input logic [7:0] o0, o1, m, input logic p, b, input tsd_op_t op,
                          input logic [8:0] mk, input logic [7:0] lat, input logic tr);
      send(o0, o1, m, p, b, 6'h00);
      check({8'h00, dec_out[29:8]}, {8'h00, op, mk, lat, tr});
   endtask

   task automatic test_bit_family;
      go(8'h0F, 8'hBA, 8'hE0, 0, 0, 0, OP_BIT_TEST, 9'h001, 8'h01, 0, 8'h00);
      go(8'h0F, 8'hBA, 8'h20, 0, 0, 0, OP_BIT_TEST, 9'h001, 8'h01, 0, 8'h00);
      go(8'h0F, 8'hA3, 8'hC0, 0, 0, 0, OP_BIT_TEST, 9'h001, 8'h01, 0, 8'h00);
      go(8'h0F, 8'hA3, 8'h00, 0, 0, 0, OP_BIT_TEST, 9'h001, 8'h07, 0, 8'h00);
      go(8'h0F, 8'hBA, 8'hF8, 0, 0, 0, OP_BIT_TEST_COMPLEMENT, 9'h001, 8'h02, 0, 8'h00);
      go(8'h0F, 8'hBB, 8'hC0, 0, 0, 0, OP_BIT_TEST_COMPLEMENT, 9'h001, 8'h02, 0, 8'h00);
      go(8'h0F, 8'hBB, 8'h40, 0, 0, 0, OP_BIT_TEST_COMPLEMENT, 9'h001, 8'h08, 0, 8'h00);
      go(8'h0F, 8'hBA, 8'hF0, 0, 0, 0, OP_BIT_TEST_CLEAR, 9'h001, 8'h02, 0, 8'h00);
      go(8'h0F, 8'hB3, 8'hC0, 0, 0, 0, OP_BIT_TEST_CLEAR, 9'h001, 8'h02, 0, 8'h00);
      go(8'h0F, 8'hB3, 8'h80, 0, 0, 0, OP_BIT_TEST_CLEAR, 9'h001, 8'h08, 0, 8'h00);
      go(8'h0F, 8'hBA, 8'hE8, 0, 0, 0, OP_BIT_TEST_SET, 9'h001, 8'h02, 0, 8'h00);
      $display("test bit_family done");
   endtask

   // Scan counts at both ends of the six-bit range
   task automatic test_scans;
      go(8'h0F, 8'hBC, 8'hC0, 0, 0, 6'h05, OP_FORWARD_BIT_SCAN, 9'h008, 8'h04, 0, 8'h00);
      go(8'h0F, 8'hBC, 8'h00, 0, 0, 6'h05, OP_FORWARD_BIT_SCAN, 9'h008, 8'h0E, 0, 8'h00);
      go(8'h0F, 8'hBC, 8'h80, 0, 0, 6'h00, OP_FORWARD_BIT_SCAN, 9'h008, 8'h09, 0, 8'h00);
      go(8'h0F, 8'hBD, 8'hC0, 0, 0, 6'h3F, OP_REVERSE_BIT_SCAN, 9'h008, 8'h04, 0, 8'h00);
      go(8'h0F, 8'hBD, 8'h40, 0, 0, 6'h3F, OP_REVERSE_BIT_SCAN, 9'h008, 8'h4A, 0, 8'h00);
      $display("test scans done");
   endtask

   task automatic test_and_forms;
      logic [7:0] o;
      for (o = 8'h20; o <= 8'h25; o++) begin
         go(o, 8'h00, 8'h40, 0, 0, 0, OP_AND, 9'h11F, 8'h01, 0, 8'h00);
      end
      for (o = 8'h80; o <= 8'h83; o++) begin
         go(o, 8'h00, 8'hE0, 0, 0, 0, OP_AND, 9'h11F, 8'h01, 0, 8'h00);
      end
      // Group 8 with another reg field must not pass for AND
      go(8'h80, 8'h00, 8'hC0, 0, 0, 0, OP_NONE, 9'h000, 8'h00, 0, 8'h00);
      $display("test and_forms done");
   endtask

   task automatic test_bound_priv;
      go_head(8'h62, 8'h00, 8'h00, 0, 0, OP_BOUND_CHECK, 9'h000, 8'h07, 0);
      go(8'h62, 8'h00, 8'h00, 0, 1, 0, OP_BOUND_CHECK, 9'h000, 8'h08, 1, 8'h05);
      go_head(8'h63, 8'h00, 8'hC0, 1, 0, OP_PRIVILEGE_ADJUST, 9'h008, 8'h09, 0);
      go_head(8'h63, 8'h00, 8'hC0, 0, 0, OP_INVALID, 9'h000, 8'h00, 0);
      $display("test bound_priv done");
   endtask

   // Two instructions on consecutive edges, then idle: output must hold
   task automatic test_back_to_back;
      @(negedge clk_sys);
      in_valid = 1'b1;
      in_instr = {8'h0F, 8'hBB, 8'h00};
      @(posedge clk_sys);
      @(negedge clk_sys);
      in_instr = {8'h0F, 8'hBC, 8'hC0};
      check({29'h0, dec_valid}, 30'h1);
      check(dec_out, {OP_BIT_TEST_COMPLEMENT, 9'h001, 8'h08, 1'b0, 8'h00});
      @(posedge clk_sys);
      @(negedge clk_sys);
      in_valid = 1'b0;
      n_sent += 2;
      check({29'h0, dec_valid}, 30'h1);
      check(dec_out, {OP_FORWARD_BIT_SCAN, 9'h008, 8'h04, 1'b0, 8'h00});
      @(negedge clk_sys);
      check({29'h0, dec_valid}, 30'h0);
      check(dec_out, {OP_FORWARD_BIT_SCAN, 9'h008, 8'h04, 1'b0, 8'h00});
      $display("test back_to_back done");
   endtask

   task automatic complete_run;
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Main sequence: reset for 12 cycles, then every scenario
   initial begin
      repeat (12) @(negedge clk_sys);
      arst_n = 1'b1;
      check({29'h0, dec_valid}, 30'h0);
      check(dec_out, 30'h0);
      test_bit_family();
      test_scans();
      test_and_forms();
      test_bound_priv();
      test_back_to_back();
      check({14'h0, taken_count}, 30'(n_sent));
      check(last_dec, {OP_FORWARD_BIT_SCAN, 9'h008, 8'h04, 1'b0, 8'h00});
      complete_run();
   end

   // Watchdog: 33 instructions need well under the 5000 cycles allowed
   initial begin
      #40000;
      num_errors++;
      complete_run();
   end
endmodule // tb_tsd_decoder
